// ==== usmr_receiver.v ====
// synchronous master receive channel with apb register slave
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "usmr_defines.vh"
module usmr_receiver (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire serial_data_pin_in,
   output wire serial_data_pin_out,
   output wire serial_data_pin_oe,
   output wire shift_clock_pin_out,
   output wire shift_clock_pin_oe,
   input wire tx_active,
   input wire tx_data_out,
   input wire tx_data_oe,
   output wire tx_abort,
   output wire rx_irq
);
   localparam ST_LOW = 1'b0;
   localparam ST_HIGH = 1'b1;

   reg [7:0] rx_status_r;
   reg [7:0] tx_status_r;
   reg [7:0] tx_data_r;
   reg [7:0] baud_r;
   reg [7:0] enables_r;
   reg overrun_r;
   reg state_r;
   reg busy_r;
   reg sclk_r;
   reg [7:0] brg_cnt_r;
   reg [3:0] bit_cnt_r;
   reg [8:0] shift_r;
   reg [2:0] din_sync_r;
   reg din_r;
   reg [31:0] rd_mux;
   reg [7:0] rx_status_nxt;
   reg state_nxt;
   reg busy_nxt;
   reg sclk_nxt;
   reg [3:0] bit_cnt_nxt;
   reg [8:0] shift_nxt;
   reg word_done;

   wire [7:0] reg_idx;
   wire idx_ok;
   wire mapped;
   wire wr_acc;
   wire rd_acc;
   wire port_en;
   wire sync_mode;
   wire clk_master;
   wire single_en;
   wire cont_en;
   wire rx_en;
   wire rx_run;
   wire brg_run;
   wire brg_tick;
   wire [3:0] word_bits;
   wire [8:0] word_bits_data;
   wire fifo_full;
   wire fifo_empty;
   wire fifo_push;
   wire fifo_pop;
   wire [`USMR_ENTRY_W-1:0] fifo_head;
   wire [`USMR_ENTRY_W-1:0] fifo_wdata;
   wire overrun_set;
   wire overrun_clr;
   wire [7:0] flags_view;

   // bus decode: word aligned, indices scaled by four
   assign reg_idx = paddr[9:2];
   assign idx_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
   assign mapped = idx_ok && ((reg_idx == `USMR_IDX_FLAGS) ||
                   (reg_idx == `USMR_IDX_ENABLES) ||
                   (reg_idx == `USMR_IDX_RXSTATUS) ||
                   (reg_idx == `USMR_IDX_RXDATA) ||
                   (reg_idx == `USMR_IDX_TXSTATUS) ||
                   (reg_idx == `USMR_IDX_TXDATA) ||
                   (reg_idx == `USMR_IDX_BAUD));
   // zero wait states; read data is captured in the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign wr_acc = psel & penable & pwrite & mapped;
   assign rd_acc = psel & penable & ~pwrite & mapped;

   assign port_en = rx_status_r[`USMR_RS_PORT_EN];
   assign sync_mode = tx_status_r[`USMR_TS_SYNC];
   assign clk_master = tx_status_r[`USMR_TS_CLK_MASTER];
   assign single_en = rx_status_r[`USMR_RS_SINGLE];
   assign cont_en = rx_status_r[`USMR_RS_CONT];
   assign rx_en = single_en | cont_en;
   assign rx_run = rx_en & port_en & sync_mode & clk_master;
   // the transmitter keeps its state but loses the pins
   assign tx_abort = rx_en & tx_active;
   assign brg_run = rx_run | (tx_status_r[`USMR_TS_TX_EN] & port_en);
   assign brg_tick = brg_run && (brg_cnt_r == 8'h00);
   assign word_bits = rx_status_r[`USMR_RS_NINE_BIT] ?
                      `USMR_BITS_LONG : `USMR_BITS_SHORT;
   assign word_bits_data = shift_nxt;

   // pins: data pin released while a receive enable is set
   assign serial_data_pin_out = tx_data_out & ~rx_en;
   assign serial_data_pin_oe = tx_data_oe & ~rx_en & port_en;
   assign shift_clock_pin_out = sclk_r;
   assign shift_clock_pin_oe = port_en & sync_mode & clk_master;

   // baud generator reloads from the divider; cleared to zero while idle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brg_cnt_r <= 8'h00;
      end else if (!brg_run) begin
         brg_cnt_r <= 8'h00;
      end else if (brg_cnt_r == 8'h00) begin
         brg_cnt_r <= baud_r;
      end else begin
         brg_cnt_r <= brg_cnt_r - 8'h01;
      end
   end

   // data pin: three stages, a level counts once the last two agree
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         din_sync_r <= 3'b000;
         din_r <= 1'b0;
      end else begin
         din_sync_r <= {din_sync_r[1:0], serial_data_pin_in};
         if (din_sync_r[1] == din_sync_r[2]) begin
            din_r <= din_sync_r[2];
         end
      end
   end

   // shift clock: low half, high half per bit, sample on the fall
   always @* begin
      state_nxt = state_r;
      busy_nxt = busy_r;
      sclk_nxt = sclk_r;
      bit_cnt_nxt = bit_cnt_r;
      shift_nxt = shift_r;
      word_done = 1'b0;
      if (!rx_run) begin
         state_nxt = ST_LOW;
         busy_nxt = 1'b0;
         sclk_nxt = 1'b0;
         bit_cnt_nxt = 4'h0;
         shift_nxt = 9'h000;
      end else if (brg_tick) begin
         case (state_r)
            ST_LOW: begin
               state_nxt = ST_HIGH;
               sclk_nxt = 1'b1;
               busy_nxt = 1'b1;
            end
            ST_HIGH: begin
               state_nxt = ST_LOW;
               sclk_nxt = 1'b0;
               // least significant bit arrives first
               shift_nxt = {din_r, shift_r[8:1]};
               if (bit_cnt_r == word_bits - 4'h1) begin
                  word_done = 1'b1;
                  bit_cnt_nxt = 4'h0;
                  busy_nxt = 1'b0;
               end else begin
                  bit_cnt_nxt = bit_cnt_r + 4'h1;
               end
            end
            default: begin
               state_nxt = ST_LOW;
               sclk_nxt = 1'b0;
            end
         endcase
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_LOW;
         busy_r <= 1'b0;
         sclk_r <= 1'b0;
         bit_cnt_r <= 4'h0;
         shift_r <= 9'h000;
      end else begin
         state_r <= state_nxt;
         busy_r <= busy_nxt;
         sclk_r <= sclk_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         shift_r <= shift_nxt;
      end
   end

   // an eight bit word sits one place too high after eight shifts
   assign fifo_wdata = rx_status_r[`USMR_RS_NINE_BIT] ?
                       {1'b0, word_bits_data[8], word_bits_data[7:0]} :
                       {2'b00, word_bits_data[8:1]};
   assign fifo_push = word_done & ~overrun_r & ~fifo_full;
   assign overrun_set = word_done & ~overrun_r & fifo_full;
   assign overrun_clr = wr_acc && (reg_idx == `USMR_IDX_RXSTATUS) &&
                        !pwdata[`USMR_RS_CONT];
   assign fifo_pop = rd_acc && (reg_idx == `USMR_IDX_RXDATA);

   usmr_fifo #(
      .WIDTH(`USMR_ENTRY_W),
      .DEPTH(`USMR_FIFO_DEPTH),
      .AW(1)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .clear(~port_en),
      .push(fifo_push),
      .wr_data(fifo_wdata),
      .pop(fifo_pop),
      .full(fifo_full),
      .empty(fifo_empty),
      .head_r(fifo_head)
   );

   // set wins over a simultaneous clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overrun_r <= 1'b0;
      end else if (overrun_set) begin
         overrun_r <= 1'b1;
      end else if (overrun_clr) begin
         overrun_r <= 1'b0;
      end
   end

   // receive status: control bits written, low bits from hardware
   always @* begin
      rx_status_nxt = rx_status_r;
      if (wr_acc && (reg_idx == `USMR_IDX_RXSTATUS)) begin
         rx_status_nxt[7:4] = pwdata[7:4];
      end
      if (word_done && !cont_en) begin
         rx_status_nxt[`USMR_RS_SINGLE] = 1'b0;
      end
      rx_status_nxt[3] = 1'b0;
      rx_status_nxt[`USMR_RS_FRAME_ERR] = fifo_head[9];
      rx_status_nxt[`USMR_RS_OVERRUN] = 1'b0;
      rx_status_nxt[`USMR_RS_NINTH] = 1'b0;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_status_r <= `USMR_RST_RXSTATUS;
         tx_status_r <= `USMR_RST_TXSTATUS;
         tx_data_r <= 8'h00;
         baud_r <= `USMR_RST_BAUD;
         enables_r <= `USMR_RST_ENABLES;
      end else begin
         rx_status_r <= rx_status_nxt;
         if (wr_acc && (reg_idx == `USMR_IDX_TXSTATUS)) begin
            tx_status_r <= {pwdata[7:4], 2'b00, 1'b1, pwdata[0]};
         end
         if (wr_acc && (reg_idx == `USMR_IDX_TXDATA)) begin
            tx_data_r <= pwdata[7:0];
         end
         if (wr_acc && (reg_idx == `USMR_IDX_BAUD)) begin
            baud_r <= pwdata[7:0];
         end
         if (wr_acc && (reg_idx == `USMR_IDX_ENABLES)) begin
            enables_r <= pwdata[7:0];
         end
      end
   end

   // receive flag is the fifo's non-empty state, no write path
   assign flags_view = {6'h00, 1'b1, ~fifo_empty};
   assign rx_irq = ~fifo_empty & enables_r[`USMR_FL_RX];

   always @* begin
      rd_mux = 32'h0000_0000;
      case (reg_idx)
         `USMR_IDX_FLAGS: rd_mux[7:0] = flags_view;
         `USMR_IDX_ENABLES: rd_mux[7:0] = enables_r;
         `USMR_IDX_RXSTATUS: begin
            rd_mux[7:0] = {rx_status_r[7:3], fifo_head[9], overrun_r,
                           fifo_head[8]};
         end
         `USMR_IDX_RXDATA: rd_mux[7:0] = fifo_head[7:0];
         `USMR_IDX_TXSTATUS: rd_mux[7:0] = tx_status_r;
         `USMR_IDX_TXDATA: rd_mux[7:0] = tx_data_r;
         `USMR_IDX_BAUD: rd_mux[7:0] = baud_r;
         default: rd_mux = 32'h0000_0000;
      endcase
      if (!idx_ok) begin
         rd_mux = 32'h0000_0000;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_mux;
      end
   end
endmodule // usmr_receiver
`default_nettype wire

// ==== usmr_defines.vh ====
// register map, field positions and reset values of the receive channel
`ifndef USMR_DEFINES_VH
`define USMR_DEFINES_VH

// register indices; byte address is four times the index
`define USMR_IDX_FLAGS     8'h10
`define USMR_IDX_ENABLES   8'h11
`define USMR_IDX_RXSTATUS  8'h13
`define USMR_IDX_RXDATA    8'h14
`define USMR_IDX_TXSTATUS  8'h15
`define USMR_IDX_TXDATA    8'h16
`define USMR_IDX_BAUD      8'h17

// receive status fields
`define USMR_RS_PORT_EN    7
`define USMR_RS_NINE_BIT   6
`define USMR_RS_SINGLE     5
`define USMR_RS_CONT       4
`define USMR_RS_FRAME_ERR  2
`define USMR_RS_OVERRUN    1
`define USMR_RS_NINTH      0

// transmit status fields
`define USMR_TS_CLK_MASTER 7
`define USMR_TS_NINE_TX    6
`define USMR_TS_TX_EN      5
`define USMR_TS_SYNC       4
`define USMR_TS_SH_EMPTY   1
`define USMR_TS_TX_NINTH   0

// flag and enable fields
`define USMR_FL_RX         0
`define USMR_FL_TX         1

// reset values
`define USMR_RST_FLAGS     8'h02
`define USMR_RST_ENABLES   8'h00
`define USMR_RST_RXSTATUS  8'h00
`define USMR_RST_TXSTATUS  8'h02
`define USMR_RST_BAUD      8'h00

// word lengths and buffering
`define USMR_BITS_SHORT    4'h8
`define USMR_BITS_LONG     4'h9
`define USMR_FIFO_DEPTH    2
`define USMR_ENTRY_W       10

`endif

// ==== usmr_fifo.v ====
// two-entry receive word store with registered head output
`timescale 1ns/1ps
`default_nettype none
module usmr_fifo #(
   parameter WIDTH = 10,
   parameter DEPTH = 2,
   parameter AW = 1
) (
   input wire pclk,
   input wire presetn,
   input wire clear,
   input wire push,
   input wire [WIDTH-1:0] wr_data,
   input wire pop,
   output wire full,
   output wire empty,
   output reg [WIDTH-1:0] head_r
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0] wptr_r;
   reg [AW-1:0] rptr_r;
   reg [AW:0] count_r;
   wire do_push;
   wire do_pop;
   wire [AW-1:0] rptr_nxt;
   wire [AW:0] left_nxt;
   wire [AW:0] count_nxt;
   integer i;

   assign full = (count_r == DEPTH);
   assign empty = (count_r == {(AW+1){1'b0}});
   // a push into a full store is refused, the caller counts it as overrun
   assign do_push = push & ~full;
   assign do_pop = pop & ~empty;
   assign rptr_nxt = do_pop ? ((rptr_r == DEPTH-1) ? {AW{1'b0}} :
                     rptr_r + 1'b1) : rptr_r;
   assign left_nxt = count_r - {{AW{1'b0}}, do_pop};
   assign count_nxt = left_nxt + {{AW{1'b0}}, do_push};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr_r <= {AW{1'b0}};
         rptr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
         head_r <= {WIDTH{1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_r[i] <= {WIDTH{1'b0}};
         end
      end else if (clear) begin
         wptr_r <= {AW{1'b0}};
         rptr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
         head_r <= {WIDTH{1'b0}};
      end else begin
         if (do_push) begin
            mem_r[wptr_r] <= wr_data;
            wptr_r <= (wptr_r == DEPTH-1) ? {AW{1'b0}} : wptr_r + 1'b1;
         end
         rptr_r <= rptr_nxt;
         count_r <= count_nxt;
         if (count_nxt == {(AW+1){1'b0}}) begin
            head_r <= {WIDTH{1'b0}};
         end else if (left_nxt == {(AW+1){1'b0}}) begin
            head_r <= wr_data;
         end else begin
            head_r <= mem_r[rptr_nxt];
         end
      end
   end
endmodule // usmr_fifo
`default_nettype wire

// ==== usmr_chk_asserts.sv ====
// port-level assertions for the receive channel
`timescale 1ns/1ps
`default_nettype none
module usmr_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic serial_data_pin_out,
   input wire logic serial_data_pin_oe,
   input wire logic shift_clock_pin_out,
   input wire logic shift_clock_pin_oe,
   input wire logic tx_active,
   input wire logic tx_data_oe,
   input wire logic tx_abort,
   input wire logic rx_irq
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   AST_NO_WAIT: assert property (pready)
      else $error("pready dropped");
   AST_ERR_ACCESS: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access");
   AST_RD_HOLD: assert property (!(psel && !penable && !pwrite)
      |=> $stable(prdata)) else $error("prdata moved without read");
   AST_CK_MASTER: assert property (
      shift_clock_pin_out |-> shift_clock_pin_oe)
      else $error("shift clock high while not master");
   AST_CK_OE_CAUSE: assert property (
      $changed(shift_clock_pin_oe) |-> $past(psel && penable && pwrite))
      else $error("clock enable moved without write");
   AST_ABORT_CAUSE: assert property (tx_abort |-> tx_active)
      else $error("abort without transmit");
   AST_ABORT_FREE: assert property (
      tx_abort |-> !serial_data_pin_oe && !serial_data_pin_out)
      else $error("data pin driven during abort");
   AST_DT_OE: assert property (serial_data_pin_oe |-> tx_data_oe)
      else $error("data pin driven without transmitter");
   AST_FLAG_DROP: assert property (
      $fell(rx_irq) |-> $past(psel && penable))
      else $error("receive flag fell without access");
endmodule // usmr_chk
bind usmr_receiver usmr_chk i_usmr_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
   .pslverr, .serial_data_pin_out, .serial_data_pin_oe,
   .shift_clock_pin_out, .shift_clock_pin_oe, .tx_active, .tx_data_oe,
   .tx_abort, .rx_irq
);
`default_nettype wire

// ==== usmr_slave.sv ====
// external serial slave feeding words on the data line
`timescale 1ns/1ps
`default_nettype none
module usmr_slave (
   input wire logic sck,
   input wire logic restart,
   input wire logic [8:0] word,
   input wire logic [3:0] nbits,
   output logic sdo
);
   logic [3:0] idx;
   logic odd;
   initial sdo = 1'b0;
   // change on the rise so the level is settled at the sampling fall;
   // every other frame is inverted so buffered words differ
   always @(posedge sck or posedge restart) begin
      if (restart) begin
         idx <= 4'h0;
         odd <= 1'b0;
         // idle line never holds the last bit
         sdo <= ~sdo;
      end else begin
         sdo <= word[idx] ^ odd;
         idx <= (idx == nbits - 4'h1) ? 4'h0 : idx + 4'h1;
         odd <= (idx == nbits - 4'h1) ? ~odd : odd;
      end
   end
endmodule // usmr_slave
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the synchronous master receive channel
`timescale 1ns/1ps
`default_nettype none
`include "usmr_defines.vh"
module tb;
   localparam logic [7:0] FL = `USMR_IDX_FLAGS;
   localparam logic [7:0] ST = `USMR_IDX_RXSTATUS;
   localparam logic [7:0] DA = `USMR_IDX_RXDATA;
   logic pclk, presetn, psel, penable, pwrite, restart, slv, sdo;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, tx_active, tx_data_out, tx_data_oe;
   logic serial_data_pin_out, serial_data_pin_oe, tx_abort, rx_irq;
   logic shift_clock_pin_out, shift_clock_pin_oe;
   logic [8:0] word;
   logic [3:0] nbits;
   logic [7:0] ri [6];
   logic [7:0] rv [6];
   int fails, checks_done, rises, n0;
   wire serial_data_pin_in;
   assign serial_data_pin_in = serial_data_pin_oe ? serial_data_pin_out : sdo;
   usmr_receiver i_usmr_receiver (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .serial_data_pin_in, .serial_data_pin_out,
      .serial_data_pin_oe, .shift_clock_pin_out, .shift_clock_pin_oe,
      .tx_active, .tx_data_out, .tx_data_oe, .tx_abort, .rx_irq
   );
   usmr_slave i_usmr_slave (
      .sck(shift_clock_pin_out), .restart, .word, .nbits, .sdo
   );
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge shift_clock_pin_out) rises++;
   function automatic logic [31:0] est(input logic nine, cont, ovr, b9);
      return 32'({1'b1, nine, 1'b0, cont, 2'b00, ovr, b9});
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] idx,
      input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= 32'(d);
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_flag;
      int n;
      n = 0;
      do begin
         apb(1'b0, FL, 8'h00);
         n++;
      end while (rd[0] !== 1'b1 && n < 200);
      chk(rd, 32'h0000_0003);
   endtask
   task automatic restart_slave;
      restart <= 1'b1;
      @(posedge pclk);
      restart <= 1'b0;
      rises = 0;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      tally_and_finish();
   end
   initial begin
      {presetn, psel, penable, pwrite, restart} = 5'h00;
      {paddr, pwdata} = 44'h000_0000_0000;
      {tx_active, tx_data_out, tx_data_oe} = 3'h0;
      word = 9'h000;
      nbits = 4'h8;
      fails = 0;
      checks_done = 0;
      rises = 0;
      ri = '{FL, 8'h11, ST, 8'h15, 8'h17, 8'h20};
      rv = '{8'h02, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
      void'($urandom(76));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ri[i]) begin
         apb(1'b0, ri[i], 8'h00);
         chk(rd, 32'(rv[i]));
         chk(32'(slv), 32'(i == 5));
      end
      apb(1'b1, FL, 8'h01);
      apb(1'b0, FL, 8'h00);
      chk(rd, 32'h0000_0002);
      $display("test registers done");
      apb(1'b1, `USMR_IDX_BAUD, 8'h04);
      apb(1'b1, `USMR_IDX_TXSTATUS, 8'h90);
      apb(1'b1, `USMR_IDX_ENABLES, 8'h01);
      for (int k = 0; k < 4; k++) begin
         nbits = k[0] ? 4'h9 : 4'h8;
         word = (k == 0) ? 9'h1ff : 9'($urandom);
         restart_slave();
         apb(1'b1, ST, {1'b1, k[0], 1'b1, 5'h00});
         wait_flag();
         @(negedge pclk);
         chk(32'(rx_irq), 32'h0000_0001);
         apb(1'b0, ST, 8'h00);
         chk({rd[31:1], rd[0] & k[0]}, est(k[0], 0, 0, k[0] & word[8]));
         apb(1'b0, DA, 8'h00);
         chk(rd, 32'(word[7:0]));
         repeat (60) @(posedge pclk);
         chk(32'(rises), 32'(nbits));
         chk(32'(rx_irq), 32'h0000_0000);
         $display("test single word %0d done", k);
      end
      nbits = 4'h9;
      word = 9'($urandom);
      {tx_active, tx_data_out, tx_data_oe} <= 3'h7;
      restart_slave();
      @(negedge pclk);
      chk(32'(serial_data_pin_oe), 32'h0000_0001);
      apb(1'b1, ST, 8'hf0);
      @(negedge pclk);
      chk(32'(tx_abort), 32'h0000_0001);
      chk(32'(serial_data_pin_oe), 32'h0000_0000);
      n0 = 0;
      while (rises < 28 && n0 < 2000) begin
         @(posedge pclk);
         n0++;
      end
      apb(1'b0, ST, 8'h00);
      chk(rd & 32'h0000_00df, est(1, 1, 1, word[8]));
      apb(1'b0, DA, 8'h00);
      chk(rd, 32'(word[7:0]));
      apb(1'b0, ST, 8'h00);
      chk(32'(rd[0]), {31'h0000_0000, ~word[8]});
      apb(1'b0, DA, 8'h00);
      chk(rd, {24'h00_0000, ~word[7:0]});
      repeat (100) @(posedge pclk);
      apb(1'b0, FL, 8'h00);
      chk(rd, 32'h0000_0002);
      apb(1'b1, ST, 8'hc0);
      apb(1'b0, ST, 8'h00);
      chk(rd & 32'h0000_00fe, 32'h0000_00c0);
      n0 = rises;
      repeat (40) @(posedge pclk);
      chk(32'(rises), 32'(n0));
      chk(32'(serial_data_pin_oe), 32'h0000_0001);
      $display("test continuous done");
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
